// >>> shared/ldlf_pkg.sv
// Package with constants and types for the load driver and bus fault block
package ldlf_pkg;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL_ONE_EN = 0;
	localparam int CTL_TWO_EN = 1;
	localparam int CTL_ONE_GATE = 2;
	localparam int CTL_TWO_GATE = 3;
	localparam int ST_ONE_LIMIT = 0;
	localparam int ST_ONE_OPEN = 1;
	localparam int ST_TWO_LIMIT = 2;
	localparam int ST_TWO_OPEN = 3;
	localparam int BST_OVERHEAT = 1;
	localparam int BST_STUCK_LOW = 2;
	localparam int BST_RX_SHORT = 3;
	// ****************************************
	// Reset values and slew codes
	// ****************************************
	localparam logic [1:0] SLEW_RESET = 2'h1;
	localparam logic [1:0] SLEW_10K4 = 2'h0;
	localparam logic [1:0] SLEW_20K = 2'h1;
	localparam logic [1:0] SLEW_FAST = 2'h2;
	localparam logic UV_DISABLE_RESET = 1'h0;
	localparam logic CUTOFF_ENABLE_RESET = 1'h1;
	localparam logic [3:0] CTL_RESET = 4'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// ****************************************
	// Interrupt source codes
	// ****************************************
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_HIGH = 4'h2;
	localparam logic [3:0] SRC_LOW = 4'h3;
	localparam logic [3:0] SRC_BUS = 4'h4;
	localparam logic [3:0] SRC_WAKE = 4'h5;
	// ****************************************
	// Timing
	// ****************************************
	localparam longint CLK_HZ = 20000000;
	localparam longint STUCK_LOW_MS = 1000;
	localparam longint STUCK_LOW_CYC = CLK_HZ * STUCK_LOW_MS / 1000;
	localparam longint WAKE_MIN_NS = 150000;
	localparam longint WAKE_MIN_CYC = (WAKE_MIN_NS * CLK_HZ + 999999999)
		/ 1000000000;
	localparam longint UV_DEGLITCH_NS = 10000;
	localparam longint UV_DEGLITCH_CYC = (UV_DEGLITCH_NS * CLK_HZ
		+ 999999999) / 1000000000;
	// ****************************************
	// Modes
	// ****************************************
	typedef enum logic [3:0] {
		LDLF_NORMAL = 4'h1,
		LDLF_NORMAL_REQ = 4'h2,
		LDLF_STOP = 4'h4,
		LDLF_SLEEP = 4'h8
	} ldlf_mode_t;
	typedef enum logic [2:0] {
		LDLF_TX_ON = 3'h1,
		LDLF_TX_FAULT = 3'h2,
		LDLF_TX_OFF = 3'h4
	} ldlf_tx_t;
endpackage : ldlf_pkg

// >>> shared/ldlf_sw_if.sv
// Interface between top and one switch pair module
`timescale 1ns/1ps
`default_nettype none
interface ldlf_sw_if;
	logic [3:0] ctl;
	logic ctl_wr;
	logic pulse_pin;
	logic overheat;
	logic overvolt_cut;
	logic force_off;
	logic [1:0] open_load;
	logic [1:0] limiting;
	logic [1:0] out_on;
	logic [3:0] status;
	logic heat_event;
	modport top (output ctl, ctl_wr, pulse_pin, overheat, overvolt_cut,
		force_off, open_load, limiting, input out_on, status, heat_event);
	modport sw (input ctl, ctl_wr, pulse_pin, overheat, overvolt_cut,
		force_off, open_load, limiting, output out_on, status, heat_event);
endinterface : ldlf_sw_if
`default_nettype wire

// >>> src/ldlf_switch_pair.sv
// One pair of load switches with pin gating, diagnostics and shutdown latch
`timescale 1ns/1ps
`default_nettype none
module ldlf_switch_pair
	import ldlf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	ldlf_sw_if.sw port
);
	logic latched_off_q;
	logic heat_q;
	logic [1:0] want;
	// Fault latch cleared only by a control write once conditions are gone
	always_ff @(posedge clk) begin
		if (rst) begin
			latched_off_q <= 1'b0;
		end else if (port.overheat || port.overvolt_cut) begin
			latched_off_q <= 1'b1;
		end else if (port.ctl_wr) begin
			latched_off_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			heat_q <= 1'b0;
		end else begin
			heat_q <= port.overheat;
		end
	end
	assign port.heat_event = port.overheat && !heat_q;
	always_comb begin
		want[0] = port.ctl[CTL_ONE_EN] &&
			(!port.ctl[CTL_ONE_GATE] || port.pulse_pin);
		want[1] = port.ctl[CTL_TWO_EN] &&
			(!port.ctl[CTL_TWO_GATE] || port.pulse_pin);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			port.out_on <= 2'h0;
		end else if (latched_off_q || port.overheat || port.overvolt_cut
			|| port.force_off) begin
			port.out_on <= 2'h0;
		end else begin
			port.out_on <= want;
		end
	end
	// Overheat shown by all four flags at once
	always_ff @(posedge clk) begin
		if (rst) begin
			port.status <= 4'h0;
		end else if (port.overheat || (latched_off_q && heat_q)) begin
			port.status <= 4'hF;
		end else begin
			port.status[ST_ONE_OPEN] <= port.open_load[0];
			port.status[ST_TWO_OPEN] <= port.open_load[1];
			port.status[ST_ONE_LIMIT] <= port.limiting[0];
			port.status[ST_TWO_LIMIT] <= port.limiting[1];
		end
	end
endmodule : ldlf_switch_pair
`default_nettype wire

// >>> src/ldlf_top.sv
// Load driver control and bus transceiver fault logic
`timescale 1ns/1ps
`default_nettype none
module ldlf_top
	import ldlf_pkg::*;
#(
	parameter longint STUCK_CYCLES = STUCK_LOW_CYC
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire ldlf_mode_t MODE,
	input wire logic DIRECT_PULSE_INPUT_PIN,
	input wire logic [3:0] HIGH_SWITCH_CONTROL_REG,
	input wire logic HIGH_CTL_WRITE,
	input wire logic [3:0] LOW_SWITCH_CONTROL_REG,
	input wire logic LOW_CTL_WRITE,
	input wire logic OVERVOLTAGE_CUTOFF_ENABLE,
	input wire logic [1:0] BUS_SLEW_SELECT_IN,
	input wire logic RECEIVE_ONLY_SELECT_IN,
	input wire logic UNDERVOLTAGE_CUTOFF_DISABLE_IN,
	input wire logic BUS_CTL_WRITE,
	input wire logic BUS_STATUS_READ,
	input wire logic HIGH_SWITCH_IRQ_MASK,
	input wire logic LOW_SWITCH_IRQ_MASK,
	input wire logic BUS_FAULT_IRQ_MASK,
	input wire logic SOURCE_READ,
	input wire logic HIGH_OVERHEAT,
	input wire logic LOW_OVERHEAT,
	input wire logic OVERVOLTAGE,
	input wire logic [1:0] HIGH_OPEN_LOAD,
	input wire logic [1:0] HIGH_LIMITING,
	input wire logic [1:0] LOW_OPEN_LOAD,
	input wire logic [1:0] LOW_LIMITING,
	input wire logic SUPPLY_UNDERVOLTAGE,
	input wire logic BUS_DRIVER_OVERHEAT,
	input wire logic TRANSMIT_IN,
	input wire logic BUS_LEVEL,
	input wire logic RECEIVE_PIN_SENSE,
	output logic [1:0] HIGH_OUT_ON,
	output logic [1:0] LOW_OUT_ON,
	output logic [3:0] HIGH_SWITCH_STATUS_REG,
	output logic [3:0] LOW_SWITCH_STATUS_REG,
	output logic [3:0] BUS_STATUS_REG,
	output logic [3:0] INTERRUPT_SOURCE_REG,
	output logic IRQ_N,
	output logic BUS_DRIVE_LOW,
	output logic RECEIVE_OUT,
	output logic [1:0] BUS_SLEW_SELECT,
	output logic RECEIVE_ONLY_SELECT,
	output logic UNDERVOLTAGE_CUTOFF_DISABLE,
	output logic WAKE_EVENT
);
	// ****************************************
	// Switch pairs
	// ****************************************
	ldlf_sw_if hi_if ();
	ldlf_sw_if lo_if ();
	logic low_mode;
	logic ov_cut;
	logic irq_mode;
	assign low_mode = (MODE == LDLF_SLEEP) || (MODE == LDLF_STOP);
	assign irq_mode = !(MODE == LDLF_SLEEP);
	assign ov_cut = OVERVOLTAGE_CUTOFF_ENABLE && OVERVOLTAGE;
	assign hi_if.ctl = HIGH_SWITCH_CONTROL_REG;
	assign hi_if.ctl_wr = HIGH_CTL_WRITE;
	assign hi_if.pulse_pin = DIRECT_PULSE_INPUT_PIN;
	assign hi_if.overheat = HIGH_OVERHEAT;
	assign hi_if.overvolt_cut = ov_cut;
	assign hi_if.force_off = 1'b0;
	assign hi_if.open_load = HIGH_OPEN_LOAD;
	assign hi_if.limiting = HIGH_LIMITING;
	assign lo_if.ctl = LOW_SWITCH_CONTROL_REG;
	assign lo_if.ctl_wr = LOW_CTL_WRITE;
	assign lo_if.pulse_pin = DIRECT_PULSE_INPUT_PIN;
	assign lo_if.overheat = LOW_OVERHEAT;
	assign lo_if.overvolt_cut = ov_cut;
	assign lo_if.force_off = low_mode;
	assign lo_if.open_load = LOW_OPEN_LOAD;
	assign lo_if.limiting = LOW_LIMITING;
	ldlf_switch_pair u_high (.clk(CORE_CLK), .rst(SYS_RST), .port(hi_if));
	ldlf_switch_pair u_low (.clk(CORE_CLK), .rst(SYS_RST), .port(lo_if));
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			HIGH_OUT_ON <= 2'h0;
			LOW_OUT_ON <= 2'h0;
			HIGH_SWITCH_STATUS_REG <= 4'h0;
			LOW_SWITCH_STATUS_REG <= 4'h0;
		end else begin
			HIGH_OUT_ON <= hi_if.out_on;
			LOW_OUT_ON <= lo_if.out_on;
			HIGH_SWITCH_STATUS_REG <= hi_if.status;
			LOW_SWITCH_STATUS_REG <= lo_if.status;
		end
	end
	// ****************************************
	// Bus control fields
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			BUS_SLEW_SELECT <= SLEW_RESET;
			UNDERVOLTAGE_CUTOFF_DISABLE <= UV_DISABLE_RESET;
		end else if (BUS_CTL_WRITE) begin
			BUS_SLEW_SELECT <= BUS_SLEW_SELECT_IN;
			UNDERVOLTAGE_CUTOFF_DISABLE <= UNDERVOLTAGE_CUTOFF_DISABLE_IN;
		end
	end
	// ****************************************
	// Bus fault detection
	// ****************************************
	logic [31:0] low_cnt_q;
	logic stuck_q;
	logic [15:0] uv_cnt_q;
	logic uv_q;
	logic rx_prev_q;
	logic rx_short_now;
	logic overheat_q;
	logic short_q;
	logic tx_on;
	logic fault_set;
	ldlf_tx_t tx_q;
	// Transmitter shutdown counter for a stuck low transmit input
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || TRANSMIT_IN) begin
			low_cnt_q <= 32'h0;
		end else if (low_cnt_q < 32'(STUCK_CYCLES)) begin
			low_cnt_q <= low_cnt_q + 32'h1;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			uv_cnt_q <= 16'h0;
			uv_q <= 1'b0;
		end else if (!SUPPLY_UNDERVOLTAGE) begin
			uv_cnt_q <= 16'h0;
			uv_q <= 1'b0;
		end else if (uv_cnt_q < 16'(UV_DEGLITCH_CYC)) begin
			uv_cnt_q <= uv_cnt_q + 16'h1;
		end else begin
			uv_q <= 1'b1;
		end
	end
	// Short seen when the transmitter state is on but the pin disagrees with the bus level
	assign rx_short_now = (tx_q == LDLF_TX_ON) &&
		(RECEIVE_PIN_SENSE != BUS_LEVEL);
	assign fault_set = BUS_DRIVER_OVERHEAT || rx_short_now ||
		(low_cnt_q >= 32'(STUCK_CYCLES));
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= RECEIVE_PIN_SENSE;
		end
	end
	// Flag sets win over read clears
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			overheat_q <= 1'b0;
			short_q <= 1'b0;
			stuck_q <= 1'b0;
		end else begin
			if (BUS_DRIVER_OVERHEAT) begin
				overheat_q <= 1'b1;
			end else if (BUS_STATUS_READ) begin
				overheat_q <= 1'b0;
			end
			if (rx_short_now) begin
				short_q <= 1'b1;
			end else if (BUS_STATUS_READ) begin
				short_q <= 1'b0;
			end
			if (low_cnt_q >= 32'(STUCK_CYCLES)) begin
				stuck_q <= 1'b1;
			end else if (BUS_STATUS_READ && TRANSMIT_IN) begin
				stuck_q <= 1'b0;
			end
		end
	end
	// ****************************************
	// Transmitter state
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			tx_q <= LDLF_TX_ON;
		end else begin
			case (tx_q)
				LDLF_TX_ON: begin
					if (fault_set) begin
						tx_q <= LDLF_TX_FAULT;
					end
				end
				LDLF_TX_FAULT: begin
					// Re-enable needs input high, overheat gone, rx moved if a short is flagged
					if (TRANSMIT_IN && !BUS_DRIVER_OVERHEAT &&
						(!short_q || RECEIVE_PIN_SENSE != rx_prev_q)) begin
						tx_q <= LDLF_TX_ON;
					end
				end
				default: begin
					tx_q <= LDLF_TX_ON;
				end
			endcase
		end
	end
	assign tx_on = (tx_q == LDLF_TX_ON) && (MODE == LDLF_NORMAL ||
		MODE == LDLF_NORMAL_REQ) && !RECEIVE_ONLY_SELECT;
	// Undervoltage cut only while idle recessive; dominant keeps driving
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			BUS_DRIVE_LOW <= 1'b0;
			RECEIVE_OUT <= 1'b1;
		end else if (!UNDERVOLTAGE_CUTOFF_DISABLE && uv_q && TRANSMIT_IN) begin
			BUS_DRIVE_LOW <= 1'b0;
			RECEIVE_OUT <= 1'b1;
		end else begin
			BUS_DRIVE_LOW <= tx_on && !TRANSMIT_IN;
			RECEIVE_OUT <= BUS_LEVEL;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			RECEIVE_ONLY_SELECT <= 1'b0;
		end else if (fault_set && tx_q == LDLF_TX_ON) begin
			RECEIVE_ONLY_SELECT <= 1'b1;
		end else if (BUS_CTL_WRITE) begin
			RECEIVE_ONLY_SELECT <= RECEIVE_ONLY_SELECT_IN;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			BUS_STATUS_REG <= 4'h0;
		end else begin
			BUS_STATUS_REG <= {short_q, stuck_q, overheat_q, 1'b0};
		end
	end
	// ****************************************
	// Wake detection in stop and sleep
	// ****************************************
	logic [15:0] wake_cnt_q;
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || !low_mode || RECEIVE_ONLY_SELECT) begin
			wake_cnt_q <= 16'h0;
			WAKE_EVENT <= 1'b0;
		end else if (!BUS_LEVEL) begin
			WAKE_EVENT <= 1'b0;
			if (wake_cnt_q < 16'(WAKE_MIN_CYC)) begin
				wake_cnt_q <= wake_cnt_q + 16'h1;
			end
		end else begin
			WAKE_EVENT <= wake_cnt_q >= 16'(WAKE_MIN_CYC);
			wake_cnt_q <= 16'h0;
		end
	end
	// ****************************************
	// Interrupt source and pin
	// ****************************************
	logic bus_fault_event;
	assign bus_fault_event = fault_set && tx_q == LDLF_TX_ON;
	// Masked sources never latch, so the pin stays high
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			INTERRUPT_SOURCE_REG <= SRC_NONE;
		end else if (irq_mode && hi_if.heat_event && HIGH_SWITCH_IRQ_MASK) begin
			INTERRUPT_SOURCE_REG <= SRC_HIGH;
		end else if (irq_mode && lo_if.heat_event && LOW_SWITCH_IRQ_MASK) begin
			INTERRUPT_SOURCE_REG <= SRC_LOW;
		end else if (irq_mode && bus_fault_event && BUS_FAULT_IRQ_MASK) begin
			INTERRUPT_SOURCE_REG <= SRC_BUS;
		end else if (WAKE_EVENT && MODE == LDLF_STOP) begin
			INTERRUPT_SOURCE_REG <= SRC_WAKE;
		end else if (SOURCE_READ) begin
			INTERRUPT_SOURCE_REG <= SRC_NONE;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			IRQ_N <= 1'b1;
		end else begin
			IRQ_N <= (INTERRUPT_SOURCE_REG == SRC_NONE);
		end
	end
endmodule : ldlf_top
`default_nettype wire

// >>> tb/ldlf_monitor.sv
// Port-level assertions for the load driver and bus fault block
`timescale 1ns/1ps
`default_nettype none
module ldlf_monitor
	import ldlf_pkg::*;
#(
	parameter longint STUCK_CYCLES = 50
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire ldlf_mode_t MODE,
	input wire logic HIGH_OVERHEAT,
	input wire logic LOW_OVERHEAT,
	input wire logic BUS_DRIVER_OVERHEAT,
	input wire logic TRANSMIT_IN,
	input wire logic HIGH_SWITCH_IRQ_MASK,
	input wire logic LOW_SWITCH_IRQ_MASK,
	input wire logic [1:0] HIGH_OUT_ON,
	input wire logic [1:0] LOW_OUT_ON,
	input wire logic [3:0] HIGH_SWITCH_STATUS_REG,
	input wire logic [3:0] BUS_STATUS_REG,
	input wire logic [3:0] INTERRUPT_SOURCE_REG,
	input wire logic BUS_DRIVE_LOW,
	input wire logic [1:0] BUS_SLEW_SELECT,
	input wire logic UNDERVOLTAGE_CUTOFF_DISABLE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	// ****************************************
	// Dominant run counter
	// ****************************************
	// Saturates so a very long dominant never wraps
	longint low_q;
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || TRANSMIT_IN)
			low_q <= 0;
		else if (low_q < STUCK_CYCLES + 4)
			low_q <= low_q + 1;
	end
	property p_high_off; HIGH_OVERHEAT |-> ##2 HIGH_OUT_ON == 2'h0; endproperty
	a_high_off: assert property (p_high_off)
		else $error("High outputs on during overheat");
	property p_high_flags;
		HIGH_OVERHEAT [*3] |-> HIGH_SWITCH_STATUS_REG == 4'hF;
	endproperty
	a_high_flags: assert property (p_high_flags)
		else $error("High status not all set in overheat");
	property p_high_mask;
		$rose(INTERRUPT_SOURCE_REG == SRC_HIGH) |-> $past(HIGH_SWITCH_IRQ_MASK, 2);
	endproperty
	a_high_mask: assert property (p_high_mask)
		else $error("High source set while masked");
	property p_low_off; LOW_OVERHEAT |-> ##2 LOW_OUT_ON == 2'h0; endproperty
	a_low_off: assert property (p_low_off)
		else $error("Low outputs on during overheat");
	property p_low_mask;
		$rose(INTERRUPT_SOURCE_REG == SRC_LOW) |-> $past(LOW_SWITCH_IRQ_MASK, 2);
	endproperty
	a_low_mask: assert property (p_low_mask)
		else $error("Low source set while masked");
	property p_low_sleep;
		(MODE == LDLF_STOP || MODE == LDLF_SLEEP) [*3] |-> LOW_OUT_ON == 2'h0;
	endproperty
	a_low_sleep: assert property (p_low_sleep)
		else $error("Low outputs on in stop or sleep");
	property p_reset_vals;
		$fell(SYS_RST) |-> BUS_SLEW_SELECT == SLEW_20K
			&& !UNDERVOLTAGE_CUTOFF_DISABLE;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("Bus control reset values wrong");
	property p_bus_heat;
		BUS_DRIVER_OVERHEAT [*3] |-> BUS_STATUS_REG[BST_OVERHEAT] && !BUS_DRIVE_LOW;
	endproperty
	a_bus_heat: assert property (p_bus_heat)
		else $error("Driver overheat not handled");
	property p_stuck;
		low_q == STUCK_CYCLES + 4 |-> BUS_STATUS_REG[BST_STUCK_LOW] && !BUS_DRIVE_LOW;
	endproperty
	a_stuck: assert property (p_stuck)
		else $error("Stuck dominant not handled");
	c_high: cover property (INTERRUPT_SOURCE_REG == SRC_HIGH);
	c_low: cover property (INTERRUPT_SOURCE_REG == SRC_LOW);
	c_stuck: cover property (BUS_STATUS_REG[BST_STUCK_LOW]);
endmodule : ldlf_monitor
bind ldlf_top ldlf_monitor #(.STUCK_CYCLES(STUCK_CYCLES)) u_mon (.*);
`default_nettype wire

// >>> tb/ldlf_bus_node.sv
// Bus wire model: pulled-up single wire, a remote node and a pin fault
`timescale 1ns/1ps
`default_nettype none
module ldlf_bus_node (
	input wire logic drive_low,
	input wire logic remote_dom,
	input wire logic short_en,
	input wire logic short_lvl,
	output logic bus_level,
	output logic rx_sense
);
	// ****************************************
	// Wired-and bus
	// ****************************************
	// Pull-up wins unless some node pulls dominant
	assign bus_level = !(drive_low || remote_dom);
	// Injected pin fault hides the true level
	assign rx_sense = short_en ? short_lvl : bus_level;
endmodule : ldlf_bus_node
`default_nettype wire

// >>> tb/tb_ldlf_top.sv
// Self-checking bench for the load driver and bus fault block
`timescale 1ns/1ps
`default_nettype none
module tb_ldlf_top
	import ldlf_pkg::*;
;
	// Short stuck count keeps the run brief
	localparam int STUCK = 300;
	logic CORE_CLK, SYS_RST, DIRECT_PULSE_INPUT_PIN, HIGH_CTL_WRITE;
	logic LOW_CTL_WRITE, OVERVOLTAGE_CUTOFF_ENABLE, RECEIVE_ONLY_SELECT_IN;
	logic UNDERVOLTAGE_CUTOFF_DISABLE_IN, BUS_CTL_WRITE, BUS_STATUS_READ;
	logic HIGH_SWITCH_IRQ_MASK, LOW_SWITCH_IRQ_MASK, BUS_FAULT_IRQ_MASK;
	logic SOURCE_READ, HIGH_OVERHEAT, LOW_OVERHEAT, OVERVOLTAGE, IRQ_N;
	logic SUPPLY_UNDERVOLTAGE, BUS_DRIVER_OVERHEAT, TRANSMIT_IN, BUS_LEVEL;
	logic RECEIVE_PIN_SENSE, BUS_DRIVE_LOW, RECEIVE_OUT, RECEIVE_ONLY_SELECT;
	logic UNDERVOLTAGE_CUTOFF_DISABLE, WAKE_EVENT, remote_dom, short_en;
	logic [3:0] HIGH_SWITCH_CONTROL_REG, LOW_SWITCH_CONTROL_REG;
	logic [3:0] HIGH_SWITCH_STATUS_REG, LOW_SWITCH_STATUS_REG;
	logic [3:0] BUS_STATUS_REG, INTERRUPT_SOURCE_REG;
	logic [1:0] BUS_SLEW_SELECT_IN, HIGH_OPEN_LOAD, HIGH_LIMITING;
	logic [1:0] LOW_OPEN_LOAD, LOW_LIMITING, HIGH_OUT_ON, LOW_OUT_ON;
	logic [1:0] BUS_SLEW_SELECT;
	ldlf_mode_t MODE;
	int n_fail = 0;
	int checks = 0;
	typedef struct packed {
		ldlf_mode_t md;
		logic pin;
		logic [3:0] hc, lc;
		logic [1:0] ol, lm, eh, el;
	} ldlf_row_t;
	// Mode, pin, controls, open, limit, expected high and low outputs
	localparam ldlf_row_t ROWS [7] = '{
		'{LDLF_NORMAL, 1'h1, 4'hF, 4'hF, 2'h0, 2'h0, 2'h3, 2'h3},
		'{LDLF_NORMAL, 1'h0, 4'hF, 4'hF, 2'h1, 2'h2, 2'h0, 2'h0},
		'{LDLF_NORMAL, 1'h0, 4'h3, 4'h3, 2'h2, 2'h1, 2'h3, 2'h3},
		'{LDLF_NORMAL_REQ, 1'h1, 4'h5, 4'hA, 2'h3, 2'h3, 2'h1, 2'h2},
		'{LDLF_NORMAL, 1'h0, 4'h6, 4'h9, 2'h0, 2'h3, 2'h2, 2'h1},
		'{LDLF_STOP, 1'h1, 4'hF, 4'hF, 2'h0, 2'h0, 2'h3, 2'h0},
		'{LDLF_SLEEP, 1'h1, 4'h3, 4'h3, 2'h0, 2'h0, 2'h3, 2'h0}};
	localparam logic [1:0] SL [3] = '{SLEW_10K4, SLEW_FAST, SLEW_20K};
	ldlf_top #(.STUCK_CYCLES(STUCK)) dut (.*);
	ldlf_bus_node node (.drive_low(BUS_DRIVE_LOW), .remote_dom(remote_dom),
		.short_en(short_en), .short_lvl(1'h1), .bus_level(BUS_LEVEL),
		.rx_sense(RECEIVE_PIN_SENSE));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask : cyc
	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr();
		HIGH_CTL_WRITE = 1'h1;
		LOW_CTL_WRITE = 1'h1;
		cyc(1);
		HIGH_CTL_WRITE = 1'h0;
		LOW_CTL_WRITE = 1'h0;
	endtask : wr
	task automatic bus_wr(input logic [1:0] s);
		BUS_SLEW_SELECT_IN = s;
		BUS_CTL_WRITE = 1'h1;
		cyc(1);
		BUS_CTL_WRITE = 1'h0;
	endtask : bus_wr
	task automatic rd();
		BUS_STATUS_READ = 1'h1;
		SOURCE_READ = 1'h1;
		cyc(1);
		BUS_STATUS_READ = 1'h0;
		SOURCE_READ = 1'h0;
	endtask : rd
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	initial begin
		CORE_CLK = 1'h0;
		forever #25 CORE_CLK = ~CORE_CLK;
	end
	// Run needs about 4000 cycles, wake test included
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end
	initial begin
		{SYS_RST, DIRECT_PULSE_INPUT_PIN, HIGH_CTL_WRITE, LOW_CTL_WRITE} = 4'hF;
		{HIGH_CTL_WRITE, LOW_CTL_WRITE, DIRECT_PULSE_INPUT_PIN} = 3'h0;
		{OVERVOLTAGE_CUTOFF_ENABLE, RECEIVE_ONLY_SELECT_IN} = 2'h0;
		{UNDERVOLTAGE_CUTOFF_DISABLE_IN, BUS_CTL_WRITE, BUS_STATUS_READ} = 3'h0;
		{LOW_SWITCH_IRQ_MASK, SOURCE_READ, HIGH_OVERHEAT, LOW_OVERHEAT} = 4'h0;
		{OVERVOLTAGE, SUPPLY_UNDERVOLTAGE, BUS_DRIVER_OVERHEAT} = 3'h0;
		{HIGH_SWITCH_IRQ_MASK, BUS_FAULT_IRQ_MASK, TRANSMIT_IN} = 3'h7;
		{remote_dom, short_en} = 2'h0;
		{HIGH_SWITCH_CONTROL_REG, LOW_SWITCH_CONTROL_REG} = 8'h00;
		{HIGH_OPEN_LOAD, HIGH_LIMITING, LOW_OPEN_LOAD, LOW_LIMITING} = 8'h00;
		BUS_SLEW_SELECT_IN = SLEW_20K;
		MODE = LDLF_NORMAL;
		cyc(16);
		SYS_RST = 1'h0;
		cyc(1);
		chk(BUS_SLEW_SELECT, SLEW_20K);
		chk(UNDERVOLTAGE_CUTOFF_DISABLE, 1'h0);
		chk(IRQ_N, 1'h1);
		foreach (SL[k]) begin
			bus_wr(SL[k]);
			cyc(2);
			chk(BUS_SLEW_SELECT, SL[k]);
		end
		foreach (ROWS[i]) begin
			{MODE, DIRECT_PULSE_INPUT_PIN} = {ROWS[i].md, ROWS[i].pin};
			HIGH_SWITCH_CONTROL_REG = ROWS[i].hc;
			LOW_SWITCH_CONTROL_REG = ROWS[i].lc;
			{HIGH_OPEN_LOAD, LOW_OPEN_LOAD} = {2{ROWS[i].ol}};
			{HIGH_LIMITING, LOW_LIMITING} = {2{ROWS[i].lm}};
			wr();
			cyc(4);
			chk(HIGH_OUT_ON, ROWS[i].eh);
			chk(LOW_OUT_ON, ROWS[i].el);
			chk(HIGH_SWITCH_STATUS_REG, {ROWS[i].ol[1], ROWS[i].lm[1],
				ROWS[i].ol[0], ROWS[i].lm[0]});
			chk(LOW_SWITCH_STATUS_REG, {ROWS[i].ol[1], ROWS[i].lm[1],
				ROWS[i].ol[0], ROWS[i].lm[0]});
		end
		// ****************************************
		// Shutdown latches
		// ****************************************
		{MODE, HIGH_OPEN_LOAD, HIGH_LIMITING} = {LDLF_NORMAL, 4'h0};
		{LOW_OPEN_LOAD, LOW_LIMITING} = 4'h0;
		{HIGH_SWITCH_CONTROL_REG, LOW_SWITCH_CONTROL_REG} = 8'h33;
		wr();
		HIGH_OVERHEAT = 1'h1;
		cyc(4);
		chk(HIGH_OUT_ON, 2'h0);
		chk(HIGH_SWITCH_STATUS_REG, 4'hF);
		chk(INTERRUPT_SOURCE_REG, SRC_HIGH);
		chk(IRQ_N, 1'h0);
		wr();
		cyc(3);
		chk(HIGH_OUT_ON, 2'h0);
		HIGH_OVERHEAT = 1'h0;
		cyc(4);
		chk(HIGH_OUT_ON, 2'h0);
		wr();
		rd();
		cyc(3);
		chk(HIGH_OUT_ON, 2'h3);
		chk(IRQ_N, 1'h1);
		for (int m = 0; m < 2; m++) begin
			LOW_SWITCH_IRQ_MASK = m[0];
			cyc(3);
			LOW_OVERHEAT = 1'h1;
			cyc(4);
			chk(LOW_OUT_ON, 2'h0);
			chk(IRQ_N, !m[0]);
			chk(INTERRUPT_SOURCE_REG, m ? SRC_LOW : SRC_NONE);
			LOW_OVERHEAT = 1'h0;
			cyc(2);
			wr();
			rd();
			cyc(3);
			chk(LOW_OUT_ON, 2'h3);
		end
		for (int en = 0; en < 2; en++) begin
			OVERVOLTAGE_CUTOFF_ENABLE = en[0];
			OVERVOLTAGE = 1'h1;
			cyc(4);
			chk(HIGH_OUT_ON, en ? 2'h0 : 2'h3);
			OVERVOLTAGE = 1'h0;
			cyc(3);
			chk(LOW_OUT_ON, en ? 2'h0 : 2'h3);
			wr();
			cyc(3);
			chk({HIGH_OUT_ON, LOW_OUT_ON}, 4'hF);
		end
		// ****************************************
		// Bus faults
		// ****************************************
		TRANSMIT_IN = 1'h0;
		cyc(STUCK + 5);
		chk(BUS_STATUS_REG[BST_STUCK_LOW], 1'h1);
		chk(BUS_DRIVE_LOW, 1'h0);
		chk({IRQ_N, INTERRUPT_SOURCE_REG}, {1'h0, SRC_BUS});
		rd();
		cyc(2);
		chk(BUS_STATUS_REG[BST_STUCK_LOW], 1'h1);
		TRANSMIT_IN = 1'h1;
		BUS_DRIVER_OVERHEAT = 1'h1;
		cyc(2);
		rd();
		cyc(2);
		chk(BUS_STATUS_REG, 4'h2);
		BUS_DRIVER_OVERHEAT = 1'h0;
		rd();
		bus_wr(SLEW_20K);
		TRANSMIT_IN = 1'h0;
		short_en = 1'h1;
		cyc(4);
		chk(BUS_STATUS_REG[BST_RX_SHORT], 1'h1);
		chk(BUS_DRIVE_LOW, 1'h0);
		{TRANSMIT_IN, short_en, remote_dom} = 3'h5;
		cyc(2);
		remote_dom = 1'h0;
		cyc(2);
		rd();
		bus_wr(SLEW_20K);
		TRANSMIT_IN = 1'h0;
		SUPPLY_UNDERVOLTAGE = 1'h1;
		cyc(230);
		chk(BUS_DRIVE_LOW, 1'h1);
		TRANSMIT_IN = 1'h1;
		cyc(3);
		chk({RECEIVE_OUT, BUS_DRIVE_LOW}, 2'h2);
		// ****************************************
		// Wake from stop
		// ****************************************
		MODE = LDLF_STOP;
		remote_dom = 1'h1;
		cyc(3005);
		chk(WAKE_EVENT, 1'h0);
		remote_dom = 1'h0;
		cyc(1);
		chk(WAKE_EVENT, 1'h1);
		cyc(1);
		chk(WAKE_EVENT, 1'h0);
		chk(INTERRUPT_SOURCE_REG, SRC_WAKE);
		cyc(1);
		chk(IRQ_N, 1'h0);
		finish_test();
	end
endmodule : tb_ldlf_top
`default_nettype wire
